/* verilog/tdc_pkg.sv */
// shared constants for the three digit bcd multiplexed counter
`default_nettype none
package tdc_pkg;
  localparam int unsigned DIGITS          = 3;
  localparam int unsigned BCD_W           = 4;
  localparam logic [3:0]  BCD_MAX         = 4'h9;
  localparam logic [3:0]  BCD_ZERO        = 4'h0;
  localparam logic [2:0]  SEL_NONE_N      = 3'h7;
  // scan oscillator divider, cycles of clk_i per internal scan step
  localparam int unsigned SCAN_DIV_DEF    = 250000;
  localparam int unsigned SCAN_CNT_W      = 24;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_LIVE        = 4'h4;
  localparam logic [3:0]  REG_HELD        = 4'h8;
  localparam logic [3:0]  REG_STAT        = 4'hC;
  // control register fields
  localparam int unsigned CTRL_RESET_BIT  = 0;
  localparam int unsigned CTRL_DIS_BIT    = 1;
  localparam int unsigned CTRL_HOLD_BIT   = 2;
  localparam int unsigned CTRL_EXTSEL_BIT = 3;
  localparam logic [3:0]  CTRL_RST_VAL    = 4'h0;

  typedef enum logic [2:0] {
    TDC_DIG0 = 3'b001,
    TDC_DIG1 = 3'b010,
    TDC_DIG2 = 3'b100
  } tdc_dig_e;
endpackage
`default_nettype wire

/* verilog/tdc_counter.sv */
// three digit bcd event counter with holding registers, scan mux and wishbone slave
//
// The placing of the registers and register access over Wishbone were decided locally.
`default_nettype none
module tdc_counter #(
  parameter int unsigned SCAN_DIV = tdc_pkg::SCAN_DIV_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        count_i,
  input  wire logic        disable_i,
  input  wire logic        hold_i,
  input  wire logic        master_reset_i,
  input  wire logic        ext_scan_i,
  input  wire logic        ext_scan_en_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [3:0]  bcd_o,
  output logic      [2:0]  digit_sel_n_o,
  output logic             overflow_o
);
  import tdc_pkg::*;

  typedef struct packed {
    logic [3:0]            cnt0;
    logic [3:0]            cnt1;
    logic [3:0]            cnt2;
    logic [3:0]            held0;
    logic [3:0]            held1;
    logic [3:0]            held2;
    logic                  count_q;
    logic                  hold_q;
    logic                  ext_q;
    tdc_dig_e              dig;
    logic [SCAN_CNT_W-1:0] div;
    logic [3:0]            ctrl;
    logic [3:0]            bcd;
    logic [2:0]            sel_n;
    logic                  ovf;
    logic                  ack;
    logic [31:0]           rdat;
  } tdc_state_s;

  tdc_state_s st_ff;
  tdc_state_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] bcd_inc(input logic [3:0] v);
    bcd_inc = (v == BCD_MAX) ? BCD_ZERO : v + 4'h1;
  endfunction

  function automatic logic [3:0] sel_held(input tdc_dig_e d, input tdc_state_s s);
    sel_held = BCD_ZERO;
    unique case (d)
      TDC_DIG0: sel_held = s.held0;
      TDC_DIG1: sel_held = s.held1;
      TDC_DIG2: sel_held = s.held2;
    endcase
  endfunction

  logic mr;
  logic dis;
  logic hold;
  logic count_fall;
  logic hold_rise;
  logic scan_step;
  logic wb_req;
  logic [SCAN_CNT_W-1:0] div_last;
  logic ext_sel;
  logic ctrl_wr;
  logic [3:0] wdat_lo;
  logic [11:0] live_cnt;
  logic [11:0] held_cnt;

  assign mr         = master_reset_i | st_ff.ctrl[CTRL_RESET_BIT];
  assign dis        = disable_i | st_ff.ctrl[CTRL_DIS_BIT];
  assign hold       = hold_i | st_ff.ctrl[CTRL_HOLD_BIT];
  assign count_fall = st_ff.count_q & ~count_i;
  assign hold_rise  = hold & ~st_ff.hold_q;
  assign wb_req     = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign div_last   = SCAN_CNT_W'(SCAN_DIV - 1);
  assign ext_sel    = ext_scan_en_i | st_ff.ctrl[CTRL_EXTSEL_BIT];
  assign ctrl_wr    = wb_cyc_i & wb_stb_i & wb_we_i & st_ff.ack & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  assign wdat_lo    = wb_dat_i[3:0];
  assign live_cnt   = {st_ff.cnt2, st_ff.cnt1, st_ff.cnt0};
  assign held_cnt   = {st_ff.held2, st_ff.held1, st_ff.held0};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.count_q = count_i;
    nxt_st.hold_q  = hold;
    nxt_st.ext_q   = ext_scan_i;
    nxt_st.ovf     = 1'b0;
    nxt_st.ack     = 1'b0;
    scan_step      = 1'b0;

    if (mr) begin
      nxt_st.cnt0 = BCD_ZERO;
      nxt_st.cnt1 = BCD_ZERO;
      nxt_st.cnt2 = BCD_ZERO;
    end else if (count_fall && !dis) begin
      nxt_st.cnt0 = bcd_inc(st_ff.cnt0);
      if (st_ff.cnt0 == BCD_MAX) begin
        nxt_st.cnt1 = bcd_inc(st_ff.cnt1);
        if (st_ff.cnt1 == BCD_MAX) begin
          nxt_st.cnt2 = bcd_inc(st_ff.cnt2);
          nxt_st.ovf  = (st_ff.cnt2 == BCD_MAX);
        end
      end
    end

    // holding registers: transparent when low, frozen after rising edge
    if (!hold || hold_rise) begin
      nxt_st.held0 = st_ff.cnt0;
      nxt_st.held1 = st_ff.cnt1;
      nxt_st.held2 = st_ff.cnt2;
    end

    // scan clock: internal divider or external clock rising edge
    if (mr) begin
      nxt_st.div = '0;
      nxt_st.dig = TDC_DIG0;
    end else begin
      if (ext_sel) begin
        scan_step  = ext_scan_i & ~st_ff.ext_q;
        nxt_st.div = '0;
      end else if (st_ff.div == div_last) begin
        scan_step  = 1'b1;
        nxt_st.div = '0;
      end else begin
        nxt_st.div = st_ff.div + 1'b1;
      end
      if (scan_step) begin
        unique case (st_ff.dig)
          TDC_DIG0: nxt_st.dig = TDC_DIG1;
          TDC_DIG1: nxt_st.dig = TDC_DIG2;
          TDC_DIG2: nxt_st.dig = TDC_DIG0;
        endcase
      end
    end

    nxt_st.bcd   = sel_held(nxt_st.dig, nxt_st);
    nxt_st.sel_n = mr ? SEL_NONE_N : ~nxt_st.dig;

    // wishbone slave, one wait state, ack for one cycle; write lands on the ack edge
    if (ctrl_wr) begin
      nxt_st.ctrl = wdat_lo;
    end
    if (wb_req) begin
      nxt_st.ack = 1'b1;
      unique case (wb_adr_i)
        REG_CTRL: nxt_st.rdat = {28'h0, st_ff.ctrl};
        REG_LIVE: nxt_st.rdat = {20'h0, st_ff.cnt2, st_ff.cnt1, st_ff.cnt0};
        REG_HELD: nxt_st.rdat = {20'h0, st_ff.held2, st_ff.held1, st_ff.held0};
        REG_STAT: nxt_st.rdat = {25'h0, st_ff.sel_n, st_ff.bcd};
        default:  nxt_st.rdat = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff       <= '0;
      st_ff.dig   <= TDC_DIG0;
      st_ff.sel_n <= SEL_NONE_N;
      st_ff.ctrl  <= CTRL_RST_VAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o      = st_ff.rdat;
  assign wb_ack_o      = st_ff.ack;
  assign bcd_o         = st_ff.bcd;
  assign digit_sel_n_o = st_ff.sel_n;
  assign overflow_o    = st_ff.ovf;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_roll;
    count_fall && !dis && !mr && st_ff.cnt0 == BCD_MAX && st_ff.cnt1 == BCD_MAX && st_ff.cnt2 == BCD_MAX;
  endsequence

  property p_ovf_roll;
    @(posedge clk_i) disable iff (rst_i) s_roll |=> overflow_o && st_ff.cnt2 == BCD_ZERO;
  endproperty
  a_ovf_roll: assert property (p_ovf_roll) else $error("overflow missing at rollover");

  property p_ovf_only;
    @(posedge clk_i) disable iff (rst_i) overflow_o |-> $past(st_ff.cnt2) == BCD_MAX && st_ff.cnt2 == BCD_ZERO;
  endproperty
  a_ovf_only: assert property (p_ovf_only) else $error("spurious overflow");

  property p_advance;
    @(posedge clk_i) disable iff (rst_i)
      count_fall && !dis && !mr |=> st_ff.cnt0 == bcd_inc($past(st_ff.cnt0));
  endproperty
  a_advance: assert property (p_advance) else $error("units decade failed to advance");

  property p_disable;
    @(posedge clk_i) disable iff (rst_i) dis && !mr |=> $stable({st_ff.cnt2, st_ff.cnt1, st_ff.cnt0});
  endproperty
  a_disable: assert property (p_disable) else $error("count changed while disabled");

  property p_mreset;
    @(posedge clk_i) disable iff (rst_i)
      mr |=> {st_ff.cnt2, st_ff.cnt1, st_ff.cnt0} == 12'h000 && digit_sel_n_o == SEL_NONE_N && st_ff.dig == TDC_DIG0;
  endproperty
  a_mreset: assert property (p_mreset) else $error("master reset did not clear");

  property p_hold_keep;
    @(posedge clk_i) disable iff (rst_i) hold && st_ff.hold_q |=> $stable({st_ff.held2, st_ff.held1, st_ff.held0});
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("held value changed under hold");

  property p_pass;
    @(posedge clk_i) disable iff (rst_i) !hold |=> st_ff.held0 == $past(st_ff.cnt0);
  endproperty
  a_pass: assert property (p_pass) else $error("holding register not transparent");

  property p_sel_match;
    @(posedge clk_i) disable iff (rst_i) !mr |=> digit_sel_n_o == ~st_ff.dig && bcd_o == sel_held(st_ff.dig, st_ff);
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("digit select and bcd disagree");

  property p_cycle;
    @(posedge clk_i) disable iff (rst_i) scan_step && !mr && st_ff.dig == TDC_DIG2 |=> st_ff.dig == TDC_DIG0;
  endproperty
  a_cycle: assert property (p_cycle) else $error("scan did not wrap to digit one");

  sequence s_carry;
    count_fall && !dis && !mr && st_ff.cnt0 == BCD_MAX;
  endsequence

  property p_carry;
    @(posedge clk_i) disable iff (rst_i) s_carry |=> st_ff.cnt1 == bcd_inc($past(st_ff.cnt1));
  endproperty
  a_carry: assert property (p_carry) else $error("carry into tens missing");

  sequence s_hold_rise;
    hold && !st_ff.hold_q;
  endsequence

  property p_hold_capture;
    @(posedge clk_i) disable iff (rst_i) s_hold_rise |=> held_cnt == $past(live_cnt);
  endproperty
  a_hold_capture: assert property (p_hold_capture) else $error("hold edge did not capture count");

  property p_ovf_pulse;
    @(posedge clk_i) disable iff (rst_i) overflow_o |=> !overflow_o;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow longer than one cycle");

  property p_scan_stop;
    @(posedge clk_i) disable iff (rst_i) mr |=> st_ff.div == '0;
  endproperty
  a_scan_stop: assert property (p_scan_stop) else $error("scan divider ran during master reset");

  property p_dig_still;
    @(posedge clk_i) disable iff (rst_i) !scan_step && !mr |=> $stable(st_ff.dig);
  endproperty
  a_dig_still: assert property (p_dig_still) else $error("selector moved without a scan step");

  property p_step_one;
    @(posedge clk_i) disable iff (rst_i) scan_step && !mr && st_ff.dig == TDC_DIG0 |=> st_ff.dig == TDC_DIG1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("scan did not move to digit two");

  property p_ext_over;
    @(posedge clk_i) disable iff (rst_i) ext_sel && !mr && !ext_scan_i |=> $stable(st_ff.dig);
  endproperty
  a_ext_over: assert property (p_ext_over) else $error("selector stepped without external edge");

  property p_sel_onehot;
    @(posedge clk_i) disable iff (rst_i) !mr |=> $onehot(~digit_sel_n_o);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("not exactly one digit selected");
endmodule
`default_nettype wire

/* tb/tdc_partner.sv */
// count pulse source standing in for the far-side event generator
`default_nettype none
module tdc_partner (
  input  wire logic clk_i,
  output logic      count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial count_o = 1'b1;
  // each level held two clocks, above the one clock minimum
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk_i);
      count_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      count_o <= 1'b1;
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/three_digit_bcd_mux_counter_bench.sv */
// self-checking bench for the three digit bcd multiplexed counter
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module three_digit_bcd_mux_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tdc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, count, dis = 1'b0, hold = 1'b0, mr = 1'b0, xs = 1'b0, xen = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ovf;
  logic [3:0] adr = 4'h0, bcd, bsel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [2:0] sel_n;
  int failures = 0, cmp_count = 0, ovf_n = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (ovf === 1'b1) ovf_n++;
  tdc_partner tdc_partner_i (.clk_i(clk_i), .count_o(count));
  tdc_counter #(.SCAN_DIV(4)) tdc_counter_i (.clk_i(clk_i), .rst_i(rst_i), .count_i(count), .disable_i(dis),
    .hold_i(hold), .master_reset_i(mr), .ext_scan_i(xs), .ext_scan_en_i(xen), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bcd_o(bcd), .digit_sel_n_o(sel_n), .overflow_o(ovf));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    $display("Error at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    bsel <= s;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // follow four selector steps, checking order and shown digit
  task automatic scan(input logic ext, input logic [11:0] held);
    int k;
    logic [2:0] s;
    for (int i = 0; i < 4; i++) begin
      s = sel_n;
      k = 0;
      while (sel_n === s && k < 60) begin @(posedge clk_i); if (ext) xs <= ~xs; k++; end
      if (k >= 60) timeout();
      if (s !== SEL_NONE_N) `CHK(sel_n, {s[1:0], s[2]})
      else `CHK(sel_n, 3'b110)
      `CHK(bcd, sel_n == 3'b110 ? held[3:0] : sel_n == 3'b101 ? held[7:4] : held[11:8])
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_count_disable();
    tdc_partner_i.pulse(123);
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h123)
    dis <= 1'b1;
    tdc_partner_i.pulse(5);
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h123)
    dis <= 1'b0;
    wb(1'b0, 4'h2, 32'h0); `CHK(q, 32'h0)
  endtask
  task automatic t_hold_scan();
    wb(1'b1, REG_CTRL, 32'h4);
    wb(1'b0, REG_CTRL, 32'h0); `CHK(q, 32'h4)
    tdc_partner_i.pulse(2);
    wb(1'b0, REG_HELD, 32'h0); `CHK(q, 32'h123)
    scan(1'b0, 12'h123);
    xen <= 1'b1;
    repeat (20) @(posedge clk_i);
    q[2:0] = sel_n;
    repeat (20) @(posedge clk_i);
    `CHK(sel_n, q[2:0])
    scan(1'b1, 12'h123);
    xen <= 1'b0;
  endtask
  task automatic t_reset_keep();
    hold <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h0);
    mr <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(sel_n, SEL_NONE_N)
    repeat (20) @(posedge clk_i);
    `CHK(sel_n, SEL_NONE_N)
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h0)
    mr <= 1'b0;
    scan(1'b0, 12'h123);
    wb(1'b0, REG_HELD, 32'h0); `CHK(q, 32'h123)
    hold <= 1'b0;
    tdc_partner_i.pulse(7);
    wb(1'b0, REG_HELD, 32'h0); `CHK(q, 32'h7)
  endtask
  task automatic t_overflow();
    tdc_partner_i.pulse(992);
    `CHK(ovf_n, 0)
    tdc_partner_i.pulse(1);
    `CHK(ovf_n, 1)
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h0)
  endtask
  // soft control bits, byte enable and status word
  task automatic t_soft_ctrl();
    logic [2:0] s;
    wb(1'b1, REG_CTRL, 32'h2, 4'h0);
    tdc_partner_i.pulse(1);
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h1)
    wb(1'b1, REG_CTRL, 32'h2);
    tdc_partner_i.pulse(3);
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h1)
    wb(1'b1, REG_CTRL, 32'h8);
    repeat (10) @(posedge clk_i);
    s = sel_n;
    repeat (20) @(posedge clk_i);
    `CHK(sel_n, s)
    scan(1'b1, 12'h001);
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h0); `CHK(q, 32'h70)
    wb(1'b0, REG_LIVE, 32'h0); `CHK(q, 32'h0)
    wb(1'b1, REG_CTRL, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_count_disable();
    t_hold_scan();
    t_reset_keep();
    t_overflow();
    t_soft_ctrl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
